// file: plac_consts.svh
// Offsets, field positions, reset values and timing counts for the
// indicator and crossover control registers.
// Assumes a 10 MHz system clock for the timing counts.
`ifndef PLAC_CONSTS_SVH
`define PLAC_CONSTS_SVH

`define PLAC_OFS_IND_CTRL     5'h18
`define PLAC_OFS_PHY_CTRL     5'h19
`define PLAC_IND_CTRL_RESET   16'h0400
`define PLAC_PHY_CTRL_RESET   16'h8000

// indicator_control fields
`define PLAC_RATE_HI          10
`define PLAC_RATE_LO          9
`define PLAC_POL_BIT          7
`define PLAC_FSEL_BIT         4
`define PLAC_FVAL_BIT         1
`define PLAC_RATE_RESET       2'h2

// phy_control fields
`define PLAC_AMDIX_BIT        15
`define PLAC_FMDIX_BIT        14
`define PLAC_PRX_BIT          13
`define PLAC_PTX_BIT          12
`define PLAC_LINK_BIT         11
`define PLAC_BYP_BIT          7
`define PLAC_CFG_BIT          5
`define PLAC_ADDR_HI          4

// Timing: flash half periods in ms, clock rate in kHz
`define PLAC_CLK_KHZ          10000
`define PLAC_T0_MS            50
`define PLAC_T1_MS            100
`define PLAC_T2_MS            200
`define PLAC_T3_MS            500
`define PLAC_STRETCH_MS       50

`endif

// file: plac_pkg.sv
// Types shared by the indicator and crossover control block.
// Assumes nothing beyond the constants header.
package plac_pkg;
    typedef logic [15:0] plac_word_t;
    typedef enum logic [1:0] {
        PLAC_RES_NONE,
        PLAC_RES_SYM,
        PLAC_RES_TX_ONLY,
        PLAC_RES_RX_ONLY
    } plac_pause_t;
endpackage

// file: plac_ctrl.sv
// Indicator control and pair crossover control registers, with the
// link indicator pin driver and the pair swap select.
// Assumes a single-cycle management register port on clk_sys_i and
// strap pins that are stable around reset release.
//
// What this block does
// R1: Flash rate field picks 50, 100, 200 or 500 ms half period; resets 2.
// R2: Indicator polarity loads from strap, software may override; 1 is high.
// R3: Force select 1 drives force value on pin, else normal activity.
// R4: Force value bit 1 read-write, resets 0, level forced on pin.
// R5: Auto crossover enable resets 1 from strap; 0 disables detection.
// R6: Forced crossover swaps receive and transmit pairs when set.
// R7: Receive pause status from pause resolution, only for full duplex.
// R8: Transmit pause status from pause resolution, only for full duplex.
// R9: Link status reads 1 only for negotiated 100 full-duplex link up.
// R10: Stretch bypass drives indicator from the synchronized activity input, skipping the stretch.
// R11: Address field reports strapped address latched on the first clock after reset; read only.
// R12: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "plac_consts.svh"

module plac_ctrl
    import plac_pkg::*;
#(
    parameter int unsigned STRETCH_MS = `PLAC_STRETCH_MS
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [4:0] reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output var  logic [15:0] reg_rdata_o,
    input  wire logic       strap_polarity_i,
    input  wire logic       strap_auto_crossover_i,
    input  wire logic [4:0] strap_mgmt_address_i,
    input  wire logic       link_up_i,
    input  wire logic       activity_i,
    input  wire logic       an_complete_i,
    input  wire logic       hcd_100fd_i,
    input  wire logic       hcd_full_duplex_i,
    input  wire logic [1:0] local_advertisement_i,
    input  wire logic [1:0] partner_advertisement_i,
    output var  logic       link_indicator_pin_o,
    output var  logic       auto_crossover_enable_o,
    output var  logic       pair_swap_o,
    output var  logic       indicator_config_o
);

    localparam int unsigned CPM = `PLAC_CLK_KHZ;
    localparam int unsigned CNT0 = `PLAC_T0_MS * CPM;
    localparam int unsigned CNT1 = `PLAC_T1_MS * CPM;
    localparam int unsigned CNT2 = `PLAC_T2_MS * CPM;
    localparam int unsigned CNT3 = `PLAC_T3_MS * CPM;
    localparam int unsigned CNTS = STRETCH_MS * CPM;

    // Reload value must fit the 32-bit stretch counter
    if (STRETCH_MS == 0 || STRETCH_MS > 32'hffffffff / CPM) begin : g_ms
        $error("plac_ctrl: STRETCH_MS out of range");
    end

    // Register fields
    logic [1:0] flash_rate;
    logic       indicator_polarity;
    logic       indicator_force_select;
    logic       indicator_force_value;
    logic       auto_crossover_enable;
    logic       force_pair_crossover;
    logic       stretch_bypass;
    logic       indicator_config;
    logic [4:0] mgmt_address;
    logic       strap_taken;
    logic       pause_rx;
    logic       pause_tx;
    logic       link_status;

    // Pin inputs: three stages, change accepted when last two agree.
    // Index 0 is activity, index 1 is link level; both share one shape.
    localparam int unsigned NPIN = 2;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_q;
    logic            act_q;
    logic            link_q;

    assign pin_raw = {link_up_i, activity_i};
    assign act_q   = pin_q[0];
    assign link_q  = pin_q[1];

    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        logic [2:0] sync;
        logic       held;
        always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sync <= 3'h0;
                held <= 1'b0;
            end else begin
                sync <= {sync[1:0], pin_raw[g]};
                // A one-cycle glitch in stage two never reaches held
                if (sync[1] == sync[2])
                    held <= sync[2];
            end
        end
        assign pin_q[g] = held;
    end

    // Address match, shared by the write and read decodes
    function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
        return a == o;
    endfunction

    wire wr_ind = reg_wr_i && hit(reg_addr_i, `PLAC_OFS_IND_CTRL);
    wire wr_phy = reg_wr_i && hit(reg_addr_i, `PLAC_OFS_PHY_CTRL);
    wire rd_ind_sel = reg_rd_i && hit(reg_addr_i, `PLAC_OFS_IND_CTRL);
    wire rd_phy_sel = reg_rd_i && hit(reg_addr_i, `PLAC_OFS_PHY_CTRL);

    // Straps caught on the first clock after release, never in reset
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_taken <= 1'b0;
            mgmt_address <= 5'h00;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            mgmt_address <= strap_mgmt_address_i; // see R11
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flash_rate             <= `PLAC_RATE_RESET; // see R1
            indicator_polarity     <= 1'b0;
            indicator_force_select <= 1'b0;
            indicator_force_value  <= 1'b0; // see R4
        end else if (!strap_taken) begin
            indicator_polarity <= strap_polarity_i; // see R2
        end else if (wr_ind) begin
            flash_rate <= reg_wdata_i[`PLAC_RATE_HI:`PLAC_RATE_LO];
            indicator_polarity     <= reg_wdata_i[`PLAC_POL_BIT]; // see R2
            indicator_force_select <= reg_wdata_i[`PLAC_FSEL_BIT];
            indicator_force_value  <= reg_wdata_i[`PLAC_FVAL_BIT]; // see R4
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            auto_crossover_enable <= 1'b1; // see R5
            force_pair_crossover  <= 1'b0;
            stretch_bypass        <= 1'b0;
            indicator_config      <= 1'b0;
        end else if (!strap_taken) begin
            auto_crossover_enable <= strap_auto_crossover_i; // see R5
        end else if (wr_phy) begin
            auto_crossover_enable <= reg_wdata_i[`PLAC_AMDIX_BIT];
            force_pair_crossover  <= reg_wdata_i[`PLAC_FMDIX_BIT];
            stretch_bypass        <= reg_wdata_i[`PLAC_BYP_BIT];
            indicator_config      <= reg_wdata_i[`PLAC_CFG_BIT];
        end
    end

    // Pause resolution, symmetric bit 0 and asymmetric bit 1
    function automatic plac_pause_t resolve(input logic [1:0] l,
                                            input logic [1:0] p);
        if (l[0] && p[0])
            return PLAC_RES_SYM;
        if (!l[0] && l[1] && p[0] && p[1])
            return PLAC_RES_TX_ONLY;
        if (l[0] && l[1] && !p[0] && p[1])
            return PLAC_RES_RX_ONLY;
        return PLAC_RES_NONE;
    endfunction

    plac_pause_t res;
    logic        pause_ok;
    logic        rx_res;
    logic        tx_res;
    always_comb begin
        res = resolve(local_advertisement_i, partner_advertisement_i);
        // Half duplex never negotiates pause
        pause_ok = hcd_full_duplex_i && an_complete_i;
        rx_res   = (res == PLAC_RES_SYM) || (res == PLAC_RES_RX_ONLY);
        tx_res   = (res == PLAC_RES_SYM) || (res == PLAC_RES_TX_ONLY);
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pause_rx    <= 1'b0;
            pause_tx    <= 1'b0;
            link_status <= 1'b0;
        end else begin
            pause_rx    <= pause_ok && rx_res; // see R7
            pause_tx    <= pause_ok && tx_res; // see R8
            link_status <= link_q && an_complete_i && hcd_100fd_i; // see R9
        end
    end

    // Flash timebase: toggle phase each half period of the chosen rate
    // Counts are fixed to the 10 MHz clock; another clock scales them
    logic [31:0] flash_cnt;
    logic        flash_phase;
    logic [31:0] flash_lim;
    always_comb begin
        case (flash_rate) // see R1
            2'h0:    flash_lim = CNT0;
            2'h1:    flash_lim = CNT1;
            2'h2:    flash_lim = CNT2;
            2'h3:    flash_lim = CNT3;
            default: flash_lim = CNT2;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flash_cnt   <= 32'h0;
            flash_phase <= 1'b0;
        end else if (flash_cnt >= flash_lim - 32'h1) begin
            flash_cnt   <= 32'h0;
            flash_phase <= ~flash_phase;
        end else begin
            flash_cnt <= flash_cnt + 32'h1;
        end
    end

    // Stretch: hold activity seen for a while so short bursts are visible
    logic [31:0] str_cnt;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
            str_cnt <= 32'h0;
        else if (act_q)
            str_cnt <= CNTS;
        else if (str_cnt != 32'h0)
            str_cnt <= str_cnt - 32'h1;
    end

    logic act_shown;
    logic ind_on;
    always_comb begin
        act_shown = stretch_bypass ? act_q : (str_cnt != 32'h0); // see R10
        // Link on solid, blinking while activity is shown
        ind_on = link_q && !(act_shown && flash_phase);
        if (indicator_force_select)
            ind_on = indicator_force_value; // see R3
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link_indicator_pin_o <= 1'b1;
        end else if (indicator_force_select) begin
            // Force value is the raw pin level, polarity applies otherwise
            link_indicator_pin_o <= indicator_force_value; // see R3
        end else begin
            link_indicator_pin_o <= indicator_polarity ? ind_on
                                                       : !ind_on; // see R2
        end
    end

    // Pair controls leave through a flop so the pins never glitch
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            auto_crossover_enable_o <= 1'b1;
            pair_swap_o             <= 1'b0;
            indicator_config_o      <= 1'b0;
        end else begin
            auto_crossover_enable_o <= auto_crossover_enable; // see R5
            pair_swap_o             <= force_pair_crossover; // see R6
            indicator_config_o      <= indicator_config;
        end
    end

    // Read data registered; reserved bits zero
    plac_word_t rd_ind;
    plac_word_t rd_phy;
    always_comb begin
        rd_ind = 16'h0000; // see R12
        rd_ind[`PLAC_RATE_HI:`PLAC_RATE_LO] = flash_rate;
        rd_ind[`PLAC_POL_BIT]  = indicator_polarity;
        rd_ind[`PLAC_FSEL_BIT] = indicator_force_select;
        rd_ind[`PLAC_FVAL_BIT] = indicator_force_value;
        rd_phy = 16'h0000; // see R12
        rd_phy[`PLAC_AMDIX_BIT] = auto_crossover_enable;
        rd_phy[`PLAC_FMDIX_BIT] = force_pair_crossover;
        rd_phy[`PLAC_PRX_BIT]   = pause_rx;
        rd_phy[`PLAC_PTX_BIT]   = pause_tx;
        rd_phy[`PLAC_LINK_BIT]  = link_status;
        rd_phy[`PLAC_BYP_BIT]   = stretch_bypass;
        rd_phy[`PLAC_CFG_BIT]   = indicator_config;
        rd_phy[`PLAC_ADDR_HI:0] = mgmt_address; // see R11
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i)
            reg_rdata_o <= 16'h0000;
        else if (rd_ind_sel)
            reg_rdata_o <= rd_ind;
        else if (rd_phy_sel)
            reg_rdata_o <= rd_phy;
        else if (reg_rd_i)
            reg_rdata_o <= 16'h0000;
    end

endmodule

`default_nettype wire

// file: plac_ctrl_sva.sv
// Checker for the indicator and crossover control block.
// Assumes it is bound to plac_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module plac_ctrl_sva #(
    parameter int unsigned STRETCH_MS = 50
) (
    input wire logic        clk_sys_i,
    input wire logic        rstn_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [4:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [4:0]  strap_mgmt_address_i,
    input wire logic        hcd_100fd_i,
    input wire logic        hcd_full_duplex_i,
    input wire logic        link_indicator_pin_o,
    input wire logic        auto_crossover_enable_o,
    input wire logic        pair_swap_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_swap_follow: assert property (
        reg_wr_i && reg_addr_i == 5'h19 |->
        ##2 pair_swap_o == $past(reg_wdata_i[14], 2)) else $error("swap bad");
    a_auto_follow: assert property (
        reg_wr_i && reg_addr_i == 5'h19 |-> ##2
        auto_crossover_enable_o == $past(reg_wdata_i[15], 2)) else $error("auto");
    a_force_pin: assert property (
        reg_wr_i && reg_addr_i == 5'h18 && reg_wdata_i[4] |-> ##2
        link_indicator_pin_o == $past(reg_wdata_i[1], 2)) else $error("pin");
    a_rd_unmapped: assert property (
        reg_rd_i && reg_addr_i[4:1] != 4'hc |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_ind_resv: assert property (
        reg_rd_i && reg_addr_i == 5'h18 |=> (reg_rdata_o & 16'hf96d) == 0)
        else $error("indicator reserved bits set");
    a_phy_resv: assert property (
        reg_rd_i && reg_addr_i == 5'h19 |=> (reg_rdata_o & 16'h0740) == 0)
        else $error("phy reserved bits set");
    a_addr_strap: assert property (
        reg_rd_i && reg_addr_i == 5'h19 |=>
        reg_rdata_o[4:0] == strap_mgmt_address_i) else $error("address");
    a_pause_half: assert property (
        (!hcd_full_duplex_i)[*3] ##0 (reg_rd_i && reg_addr_i == 5'h19)
        |=> reg_rdata_o[13:12] == 2'b00) else $error("pause without fd");
    a_link_gate: assert property (
        (!hcd_100fd_i)[*4] ##0 (reg_rd_i && reg_addr_i == 5'h19)
        |=> !reg_rdata_o[11]) else $error("link status without 100fd");
    a_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
endmodule
bind plac_ctrl plac_ctrl_sva #(.STRETCH_MS(STRETCH_MS)) plac_ctrl_sva_i (
    .clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .strap_mgmt_address_i, .hcd_100fd_i, .hcd_full_duplex_i,
    .link_indicator_pin_o, .auto_crossover_enable_o, .pair_swap_o);
`default_nettype wire

// file: plac_link_model.sv
// Far side: cable link level and activity events.
// Assumes the bench enables link and activity; both are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module plac_link_model (
    input  wire logic link_en_i,
    input  wire logic act_en_i,
    output var  logic link_up_o,
    output var  logic activity_o
);
    // Odd delays keep edges off the system clock grid
    initial link_up_o = 1'b0;
    always @(link_en_i) link_up_o <= #37 link_en_i;
    initial activity_o = 1'b0;
    always #73 activity_o = act_en_i & link_up_o & 1'($urandom_range(1));
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the indicator and crossover control block.
// Assumes the design, its bound checker and the far-side model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import plac_pkg::*;
    typedef struct packed {plac_word_t v; plac_word_t m;} plac_note_t;
    logic        clk_sys_i, rstn_i, reg_wr_i, reg_rd_i;
    logic [4:0]  reg_addr_i, strap_mgmt_address_i;
    plac_word_t  reg_wdata_i, reg_rdata_o;
    logic        strap_polarity_i, strap_auto_crossover_i, link_up_i;
    logic        activity_i, an_complete_i, hcd_100fd_i, hcd_full_duplex_i;
    logic [1:0]  local_advertisement_i, partner_advertisement_i, l, p;
    logic        link_indicator_pin_o, auto_crossover_enable_o, pair_swap_o;
    logic        indicator_config_o, link_en, act_en;
    logic [2:0]  e;
    int          num_errors, num_checks;
    plac_note_t  notes[$];
    plac_note_t  n;
    // Short stretch: 1 ms, 10000 clocks, against the default 50 ms
    plac_ctrl #(.STRETCH_MS(1)) plac_ctrl_i (.clk_sys_i, .rstn_i, .reg_wr_i,
        .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .strap_polarity_i,
        .strap_auto_crossover_i, .strap_mgmt_address_i, .link_up_i,
        .activity_i, .an_complete_i, .hcd_100fd_i, .hcd_full_duplex_i,
        .local_advertisement_i, .partner_advertisement_i,
        .link_indicator_pin_o, .auto_crossover_enable_o, .pair_swap_o,
        .indicator_config_o);
    plac_link_model plac_link_model_i (.link_en_i(link_en), .act_en_i(act_en),
        .link_up_o(link_up_i), .activity_o(activity_i));
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(string name, plac_word_t exp, plac_word_t got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [4:0] a, plac_word_t d);
        @(negedge clk_sys_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(logic [4:0] a, plac_word_t v, plac_word_t m);
        @(negedge clk_sys_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        notes.push_back('{v & m, m});
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
    endtask
    task automatic do_reset(logic pol, logic ax);
        rstn_i = 1'b0;
        {an_complete_i, hcd_100fd_i, hcd_full_duplex_i} = '0;
        strap_polarity_i = pol;
        strap_auto_crossover_i = ax;
        strap_mgmt_address_i = 5'($urandom);
        repeat (16) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check("auto", 16'(ax), 16'(auto_crossover_enable_o));
        check("swap", 16'h0, 16'(pair_swap_o));
        rd(5'h18, 16'h0400 | 16'(pol) << 7, 16'hffff);
        rd(5'h19, 16'(ax) << 15 | 16'(strap_mgmt_address_i), 16'hffff);
    endtask
    // Result watcher: read data lands one edge after the strobe
    always @(posedge clk_sys_i) begin
        if (rstn_i === 1'b1 && reg_rd_i === 1'b1) begin
            #1;
            n = notes.pop_front();
            check("rdata", n.v, reg_rdata_o & n.m);
        end
    end
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        summarize();
    end
    initial begin
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, link_en, act_en} = '0;
        {local_advertisement_i, partner_advertisement_i} = '0;
        num_errors = 0;
        num_checks = 0;
        void'($urandom(91662));
        do_reset(1'b1, 1'b0);
        wr(5'h18, 16'hffff);
        rd(5'h18, 16'h0692, 16'hffff);
        link_en = 1'b1;
        act_en = 1'b1;
        // Forced level must ignore activity and polarity
        for (int i = 0; i < 4; i++) begin
            wr(5'h18, 16'h0010 | 16'(i % 2) << 1 | 16'(i) << 9);
            repeat (2) @(negedge clk_sys_i);
            check("pin", 16'(i % 2), 16'(link_indicator_pin_o));
            rd(5'h18, 16'h0010 | 16'(i % 2) << 1 | 16'(i) << 9, 16'hffff);
        end
        for (int i = 0; i < 4; i++) begin
            wr(5'h19, 16'(i) << 14 | 16'h00ff);
            repeat (2) @(negedge clk_sys_i);
            check("swap", 16'(i % 2), 16'(pair_swap_o));
            check("auto", 16'(i / 2), 16'(auto_crossover_enable_o));
            check("config", 16'h1, 16'(indicator_config_o));
            rd(5'h19, 16'(i) << 14 | 16'h00a0 | 16'(strap_mgmt_address_i),
               16'hffff);
        end
        act_en = 1'b0;
        for (int i = 0; i < 2; i++) begin
            wr(5'h18, 16'(i) << 7);
            repeat (8) @(negedge clk_sys_i);
            check("pin", 16'(i), 16'(link_indicator_pin_o));
        end
        wr(5'h1a, 16'hffff);
        rd(5'h1a, 16'h0000, 16'hffff);
        rd(5'h18, 16'h0080, 16'hffff);
        for (int i = 0; i < 32; i++) begin
            @(negedge clk_sys_i);
            {local_advertisement_i, partner_advertisement_i} = 4'(i);
            an_complete_i = 1'($urandom_range(3) != 0);
            hcd_full_duplex_i = 1'($urandom_range(1));
            hcd_100fd_i = hcd_full_duplex_i & 1'($urandom_range(1));
            l = local_advertisement_i;
            p = partner_advertisement_i;
            e[2] = an_complete_i & hcd_full_duplex_i &
                   (l[0] & p[0] | (l == 2'b11 && p == 2'b10));
            e[1] = an_complete_i & hcd_full_duplex_i &
                   (l[0] & p[0] | (l == 2'b10 && p == 2'b11));
            e[0] = an_complete_i & hcd_100fd_i;
            repeat (8) @(negedge clk_sys_i);
            rd(5'h19, 16'(e) << 11, 16'h3800);
        end
        do_reset(1'b0, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
